// ---- src/vfdcw_regs.svh ----
`ifndef VFDCW_REGS_SVH
`define VFDCW_REGS_SVH

// ----------------------------------------------------------------------------
// Opcodes, first-byte bits 7:4 read as a number
// ----------------------------------------------------------------------------
`define VFDCW_OP_CHAR_A   4'h1
`define VFDCW_OP_PAT_A    4'h2
`define VFDCW_OP_SYM_A    4'h3
`define VFDCW_OP_DUTY     4'h5
`define VFDCW_OP_DIGITS   4'h6
`define VFDCW_OP_LIGHTS   4'h7
`define VFDCW_OP_CHAR_B   4'h9
`define VFDCW_OP_PAT_B    4'ha
`define VFDCW_OP_SYM_B    4'hb
`define VFDCW_OP_STANDBY  4'hf

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define VFDCW_OP_MSB      7
`define VFDCW_OP_LSB      4
`define VFDCW_LINE_BIT    7
`define VFDCW_ADDR_MSB    3
`define VFDCW_LIGHT_OFF   0
`define VFDCW_LIGHT_ON    1

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define VFDCW_RST_ADDR    4'h0
`define VFDCW_RST_DUTY    10'h000
`define VFDCW_RST_DIGITS  4'h0
`define VFDCW_DUTY_MAX    10'h3c0
`define VFDCW_PAT_LAST    3'h4
`define VFDCW_PAT_STRIDE  5
`define VFDCW_PAT_ROWS    7
`define VFDCW_USER_CODES  8'h10

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define VFDCW_BYTE_LAST   3'h7
`define VFDCW_SLOT_TICKS  1024

`endif

// ---- src/vfdcw_pkg.sv ----
package vfdcw_pkg;

  typedef enum logic [2:0]
  {
    ST_CMD  = 3'b000,
    ST_CHAR = 3'b001,
    ST_PAT  = 3'b010,
    ST_SYM  = 3'b011,
    ST_DUTY = 3'b100
  } vfdcw_state_t;

  typedef struct packed
  {
    logic [9:0] duty;
    logic [3:0] digits;
    logic       all_on;
    logic       all_off;
    logic       standby;
  } vfdcw_cfg_t;

endpackage

// ---- src/vfdcw_link_rx.sv ----
`timescale 1ns/1ns
`include "vfdcw_regs.svh"

module vfdcw_link_rx
(
  // Link pins
  input  wire logic       shift_clock_n_in,
  input  wire logic       cs_n_in,
  input  wire logic       serial_data_in,
  // Received byte, held until the next one
  output logic      [7:0] byte_out,
  output logic            byte_tgl_out
);

  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] byte_ff = 8'h00;
  logic [7:0] nxt_byte;
  logic       tgl_ff = 1'b0;
  logic       nxt_tgl;

  always_comb
  begin
    nxt_cnt   = 3'(cnt_ff + 3'h1);
    nxt_shift = {serial_data_in, shift_ff[7:1]};
    nxt_byte  = byte_ff;
    nxt_tgl   = tgl_ff;
    if (cnt_ff == `VFDCW_BYTE_LAST)
    begin
      nxt_byte = nxt_shift;
      nxt_tgl  = ~tgl_ff;
    end
  end

  // The shift clock stops between frames, so select high clears framing directly.
  // Select gates framing
  always_ff @(posedge shift_clock_n_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      cnt_ff   <= 3'h0;
      shift_ff <= 8'h00;
    end
    else
    begin
      cnt_ff   <= nxt_cnt;
      shift_ff <= nxt_shift;
    end
  end

  // Byte and toggle survive the end of a frame for the core to pick up.
  always_ff @(posedge shift_clock_n_in)
  begin
    if (!cs_n_in)
    begin
      byte_ff <= nxt_byte;
      tgl_ff  <= nxt_tgl;
    end
  end

  assign byte_out     = byte_ff;
  assign byte_tgl_out = tgl_ff;

endmodule

// ---- src/vfdcw_top.sv ----
// Behaviour
// - Select low enables transfer; shift clock and data ignored while high.
// - Data bit shifts in on each rising edge of the shift clock.
// - Eighth bit makes an internal load strobe committing the byte.
// - Select falling edge restarts byte framing in groups of eight.
// - Consecutive data bytes advance the RAM address automatically.
// - Four-bit address steps by one and wraps fifteen to zero.
// - Reset clears pointers, sixteen digits, duty zero, all-off mode.
// - Reset drives every segment and symbol output low.
// - First byte bits 0..3 give the target RAM address.
// - Sixteen character entries, address n drives grid output bit n.
// - Character write stores second byte as an 8-bit code.
// - Stored code becomes a 5x7 pattern via ROM or user RAM.
// - Codes zero to fifteen select user pattern RAM entries.
// - Pattern write takes five bytes, byte k bit j to k+5j.
// - Symbol write stores only data bit zero.
// - Symbol bit drives the symbol anode in its grid slot.
// - Test and undefined commands have no defined effect.
// - Ten-bit duty, values above 960 saturate at 960.
// - Lights-on beats lights-off; both clear is normal display.
// - Select falling edge leaves standby.
`timescale 1ns/1ns
`include "vfdcw_regs.svh"

module vfdcw_top
  import vfdcw_pkg::*;
#(
  parameter int SLOT_TICKS = `VFDCW_SLOT_TICKS
)
(
  // Core clock and reset
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  // Serial link
  input  wire logic              shift_clock_n_in,
  input  wire logic              cs_n_in,
  input  wire logic              serial_data_in,
  // Display drive
  output logic       [15:0]      grid_output_out,
  output logic       [1:0][34:0] anode_output_out,
  output logic       [1:0]       symbol_output_out,
  // Status
  output logic                   standby_out
);

  // --------------------------------------------------------------------------
  // Link receiver and crossing
  // --------------------------------------------------------------------------
  logic [7:0] rx_byte;
  logic       rx_tgl;
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [1:0] s3_ff;
  logic [1:0] stab_ff;
  logic [1:0] nxt_stab;
  logic [1:0] prev_ff;
  logic       cs_fall;
  logic       byte_evt;

  vfdcw_link_rx u_vfdcw_link_rx
  (
    .shift_clock_n_in (shift_clock_n_in),
    .cs_n_in          (cs_n_in),
    .serial_data_in   (serial_data_in),
    .byte_out         (rx_byte),
    .byte_tgl_out     (rx_tgl)
  );

  // A change counts only once the second and third stages agree.
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++)
    begin : g_sync
      always_comb
      begin
        nxt_stab[gs] = stab_ff[gs];
        if (srst_in || (s2_ff[gs] == s3_ff[gs]))
        begin
          nxt_stab[gs] = s3_ff[gs];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    s1_ff   <= {rx_tgl, cs_n_in};
    s2_ff   <= s1_ff;
    s3_ff   <= s2_ff;
    stab_ff <= nxt_stab;
    prev_ff <= srst_in ? nxt_stab : stab_ff;
  end

  assign cs_fall  = prev_ff[0] & ~stab_ff[0];
  assign byte_evt = prev_ff[1] ^ stab_ff[1];

  // --------------------------------------------------------------------------
  // Command interpreter
  // --------------------------------------------------------------------------
  vfdcw_state_t state_ff;
  vfdcw_state_t nxt_state;
  vfdcw_cfg_t   cfg_ff;
  vfdcw_cfg_t   nxt_cfg;
  logic [3:0]   addr_ff;
  logic [3:0]   nxt_addr;
  logic         line_ff;
  logic         nxt_line;
  logic [2:0]   pidx_ff;
  logic [2:0]   nxt_pidx;
  logic [34:0]  pat_ff;
  logic [34:0]  nxt_pat;
  logic [1:0]   duty_lo_ff;
  logic [1:0]   nxt_duty_lo;
  logic [9:0]   duty_raw;
  logic [3:0]   op;
  logic         we_char;
  logic         we_pat;
  logic         we_sym;

  assign op       = rx_byte[`VFDCW_OP_MSB:`VFDCW_OP_LSB];
  assign duty_raw = {rx_byte, duty_lo_ff};

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_cfg     = cfg_ff;
    nxt_addr    = addr_ff;
    nxt_line    = line_ff;
    nxt_pidx    = pidx_ff;
    nxt_pat     = pat_ff;
    nxt_duty_lo = duty_lo_ff;
    we_char     = 1'b0;
    we_pat      = 1'b0;
    we_sym      = 1'b0;
    if (cs_fall)
    begin
      nxt_cfg.standby = 1'b0;
      nxt_state       = ST_CMD;
    end
    else if (byte_evt && !cfg_ff.standby)
    begin
      case (state_ff)
        ST_CMD:
        begin
          nxt_addr = rx_byte[`VFDCW_ADDR_MSB:0];
          nxt_line = rx_byte[`VFDCW_LINE_BIT];
          nxt_pidx = 3'h0;
          if (op == `VFDCW_OP_CHAR_A || op == `VFDCW_OP_CHAR_B)
            nxt_state = ST_CHAR;
          else if (op == `VFDCW_OP_PAT_A || op == `VFDCW_OP_PAT_B)
            nxt_state = ST_PAT;
          else if (op == `VFDCW_OP_SYM_A || op == `VFDCW_OP_SYM_B)
            nxt_state = ST_SYM;
          else if (op == `VFDCW_OP_DUTY)
          begin
            nxt_duty_lo = rx_byte[1:0];
            nxt_state   = ST_DUTY;
          end
          else if (op == `VFDCW_OP_DIGITS)
            nxt_cfg.digits = rx_byte[3:0];
          else if (op == `VFDCW_OP_LIGHTS)
          begin
            nxt_cfg.all_off = rx_byte[`VFDCW_LIGHT_OFF];
            nxt_cfg.all_on  = rx_byte[`VFDCW_LIGHT_ON];
          end
          else if (op == `VFDCW_OP_STANDBY)
            nxt_cfg.standby = 1'b1;
        end
        ST_CHAR:
        begin
          we_char  = 1'b1;
          nxt_addr = 4'(addr_ff + 4'h1);
        end
        ST_SYM:
        begin
          we_sym   = 1'b1;
          nxt_addr = 4'(addr_ff + 4'h1);
        end
        ST_PAT:
        begin
          for (int j = 0; j < `VFDCW_PAT_ROWS; j++)
          begin
            nxt_pat[int'(pidx_ff) + `VFDCW_PAT_STRIDE * j] = rx_byte[j];
          end
          if (pidx_ff == `VFDCW_PAT_LAST)
          begin
            we_pat   = 1'b1;
            nxt_pidx = 3'h0;
            nxt_addr = 4'(addr_ff + 4'h1);
          end
          else
          begin
            nxt_pidx = 3'(pidx_ff + 3'h1);
          end
        end
        ST_DUTY:
        begin
          nxt_cfg.duty = (duty_raw > `VFDCW_DUTY_MAX) ? `VFDCW_DUTY_MAX : duty_raw;
          nxt_state    = ST_CMD;
        end
        default:
        begin
          nxt_state = ST_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state_ff   <= ST_CMD;
      cfg_ff     <= '{duty: `VFDCW_RST_DUTY, digits: `VFDCW_RST_DIGITS,
                      all_on: 1'b0, all_off: 1'b1, standby: 1'b0};
      addr_ff    <= `VFDCW_RST_ADDR;
      line_ff    <= 1'b0;
      pidx_ff    <= 3'h0;
      pat_ff     <= '0;
      duty_lo_ff <= 2'h0;
    end
    else
    begin
      state_ff   <= nxt_state;
      cfg_ff     <= nxt_cfg;
      addr_ff    <= nxt_addr;
      line_ff    <= nxt_line;
      pidx_ff    <= nxt_pidx;
      pat_ff     <= nxt_pat;
      duty_lo_ff <= nxt_duty_lo;
    end
  end

  assign standby_out = cfg_ff.standby;

  // --------------------------------------------------------------------------
  // Scan timing
  // --------------------------------------------------------------------------
  logic [9:0] tick_ff;
  logic [9:0] nxt_tick;
  logic [3:0] digit_ff;
  logic [3:0] nxt_digit;
  logic [3:0] last_digit;

  assign last_digit = (cfg_ff.digits == 4'h0) ? 4'hf : 4'(cfg_ff.digits - 4'h1);

  always_comb
  begin
    nxt_tick  = tick_ff;
    nxt_digit = digit_ff;
    if (!cfg_ff.standby)
    begin
      nxt_tick = 10'(tick_ff + 10'h001);
      if (tick_ff == 10'(SLOT_TICKS - 1))
      begin
        nxt_tick  = 10'h000;
        nxt_digit = (digit_ff >= last_digit) ? 4'h0 : 4'(digit_ff + 4'h1);
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      tick_ff  <= 10'h000;
      digit_ff <= 4'h0;
    end
    else
    begin
      tick_ff  <= nxt_tick;
      digit_ff <= nxt_digit;
    end
  end

  // --------------------------------------------------------------------------
  // Display memories and anode and symbol drive, one copy per line; grid drive shared by both lines
  // --------------------------------------------------------------------------
  // Stand-in glyph table; the production character set replaces this function.
  function automatic logic [34:0] pattern_rom(input logic [7:0] code);
    pattern_rom = {3'h0, code, code, code, code};
  endfunction

  logic lit;
  logic blank;
  assign lit   = (tick_ff < cfg_ff.duty) && !cfg_ff.standby;
  assign blank = cfg_ff.standby || (cfg_ff.all_off && !cfg_ff.all_on);

  logic [15:0] nxt_grid;
  always_comb
  begin
    nxt_grid = 16'h0000;
    if (lit)
      nxt_grid[digit_ff] = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    grid_output_out <= srst_in ? 16'h0000 : nxt_grid;
  end

  genvar gl;
  generate
    for (gl = 0; gl < 2; gl++)
    begin : g_line
      logic [7:0]  char_code_ram    [16];
      logic [34:0] user_pattern_ram [16];
      logic        symbol_ram       [16];
      logic [7:0]  code;
      logic [34:0] glyph;
      logic [34:0] nxt_anode;
      logic        nxt_sym;

      always_ff @(posedge clk_in)
      begin
        if (we_char && line_ff == 1'(gl))
          char_code_ram[addr_ff] <= rx_byte;
        if (we_pat && line_ff == 1'(gl))
          user_pattern_ram[addr_ff] <= nxt_pat;
        if (we_sym && line_ff == 1'(gl))
          symbol_ram[addr_ff] <= rx_byte[0];
      end

      assign code  = char_code_ram[digit_ff];
      assign glyph = (code < `VFDCW_USER_CODES) ? user_pattern_ram[code[3:0]]
                                                : pattern_rom(code);

      always_comb
      begin
        nxt_anode = '0;
        nxt_sym   = 1'b0;
        if (blank)
        begin
          nxt_anode = '0;
          nxt_sym   = 1'b0;
        end
        else if (cfg_ff.all_on)
        begin
          nxt_anode = '1;
          nxt_sym   = 1'b1;
        end
        else if (lit)
        begin
          nxt_anode = glyph;
          nxt_sym   = symbol_ram[digit_ff];
        end
      end

      always_ff @(posedge clk_in)
      begin
        anode_output_out[gl]  <= srst_in ? 35'h0 : nxt_anode;
        symbol_output_out[gl] <= srst_in ? 1'b0 : nxt_sym;
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  property p_reset_defaults;
    @(posedge clk_in) disable iff (1'b0)
    srst_in |=> (cfg_ff.duty == 10'h000) && cfg_ff.all_off && (cfg_ff.digits == 4'h0);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("Reset did not load the default configuration.");

  property p_reset_outputs;
    @(posedge clk_in) disable iff (1'b0)
    srst_in |=> (anode_output_out == '0) && (symbol_output_out == 2'h0);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("Anode outputs not low after reset.");

  property p_addr_wrap;
    (state_ff == ST_CHAR) && byte_evt && !cs_fall && !cfg_ff.standby && (addr_ff == 4'hf)
      |=> (addr_ff == 4'h0);
  endproperty
  a_addr_wrap: assert property (p_addr_wrap)
    else $error("Address did not wrap to zero.");

  property p_addr_inc;
    (state_ff == ST_SYM) && byte_evt && !cs_fall && !cfg_ff.standby
      |=> (addr_ff == 4'($past(addr_ff) + 4'h1));
  endproperty
  a_addr_inc: assert property (p_addr_inc)
    else $error("Address did not advance after a data byte.");

  property p_duty_cap;
    cfg_ff.duty <= 10'h3c0;
  endproperty
  a_duty_cap: assert property (p_duty_cap)
    else $error("Duty above the saturation value.");

  property p_all_on;
    (cfg_ff.all_on && !cfg_ff.standby) ##1 (cfg_ff.all_on && !cfg_ff.standby)
      |-> (anode_output_out == '1) && (symbol_output_out == 2'h3);
  endproperty
  a_all_on: assert property (p_all_on)
    else $error("Lights-on did not force outputs high.");

  property p_all_off;
    (cfg_ff.all_off && !cfg_ff.all_on) [*2] |-> (anode_output_out == '0);
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("Lights-off did not force outputs low.");

  property p_wake;
    cfg_ff.standby && cs_fall |=> !cfg_ff.standby;
  endproperty
  a_wake: assert property (p_wake)
    else $error("Select falling edge did not leave standby.");

  property p_standby_dark;
    cfg_ff.standby [*2] |-> (grid_output_out == 16'h0000) && $stable(tick_ff);
  endproperty
  a_standby_dark: assert property (p_standby_dark)
    else $error("Scan running during standby.");

  property p_sym_bit0;
    we_sym && line_ff == 1'b0 |=> g_line[0].symbol_ram[$past(addr_ff)] == $past(rx_byte[0]);
  endproperty
  a_sym_bit0: assert property (p_sym_bit0)
    else $error("Symbol write stored the wrong bit.");

  c_char_write: cover property (we_char ##[1:300] we_char);
  c_pat_write: cover property (we_pat);
  c_duty_set: cover property ((state_ff == ST_DUTY) ##1 (state_ff == ST_CMD));
  c_wake: cover property (cfg_ff.standby ##1 !cfg_ff.standby);

endmodule

// ---- dv/vfdcw_host_model.sv ----
`timescale 1ns/1ns

module vfdcw_host_model
(
  // Link pins toward the device
  output logic shift_clock_n_out,
  output logic cs_n_out,
  output logic serial_data_out
);
  // ---------------------------------------------------------------------------
  // Host side of the serial link
  // ---------------------------------------------------------------------------
  initial
  begin
    shift_clock_n_out = 1'b1;
    cs_n_out          = 1'b1;
    serial_data_out   = 1'b0;
  end

  task automatic open_frame();
    cs_n_out = 1'b0;
    #250;
  endtask

  task automatic close_frame();
    #250;
    cs_n_out = 1'b1;
    #800;
  endtask

  // n bits LSB first
  // The shift clock only runs inside a byte, and the released data line shows the
  // inverse of its last bit so a device that samples late sees wrong data.
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      shift_clock_n_out = 1'b0;
      serial_data_out   = b[i];
      #3;
      shift_clock_n_out = 1'b1;
      #3;
    end
    serial_data_out = ~serial_data_out;
    #1500;
  endtask
endmodule

// ---- dv/vfd_serial_command_ram_writer_tb.sv ----
`timescale 1ns/1ns

module vfd_serial_command_ram_writer_tb;
  // ---------------------------------------------------------------------------
  // Bench state
  // ---------------------------------------------------------------------------
  localparam int SLOT  = 16;
  localparam int LIMIT = 30000;
  logic             clk_in = 1'b0;
  logic             srst_in = 1'b1;
  logic             sck_n;
  logic             cs_n;
  logic             sda;
  logic [15:0]      grid;
  logic [1:0][34:0] anode;
  logic [1:0]       sym;
  logic             stby;
  int               fail_count = 0;
  int               check_count = 0;
  int               seed = 32'h4767;
  int               cycles = 0;
  int               lit_n = 0;
  logic [7:0]       code_m [2][16];
  logic [34:0]      pat_m [2][16];
  logic             sym_m [2][16];
  logic [7:0]       lights [4] = '{8'h70, 8'h72, 8'h73, 8'h71};
  int               modes [4] = '{0, 1, 1, 2};

  always #50 clk_in = ~clk_in;

  vfdcw_top #(.SLOT_TICKS(SLOT)) u_vfdcw_top
  (
    .clk_in           (clk_in),
    .srst_in          (srst_in),
    .shift_clock_n_in (sck_n),
    .cs_n_in          (cs_n),
    .serial_data_in   (sda),
    .grid_output_out  (grid),
    .anode_output_out (anode),
    .symbol_output_out(sym),
    .standby_out      (stby)
  );

  vfdcw_host_model u_vfdcw_host_model
  (
    .shift_clock_n_out(sck_n),
    .cs_n_out         (cs_n),
    .serial_data_out  (sda)
  );

  task automatic check_pattern(input string what, input logic [34:0] e, input logic [34:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_level(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fail_count++;
      $display("Error run length expected %0d seen %0d", LIMIT - 1, cycles);
      stop_test();
    end
  end

  task automatic frame(input logic [7:0] q[$]);
    u_vfdcw_host_model.open_frame();
    foreach (q[i])
      u_vfdcw_host_model.send_bits(q[i], 8);
    u_vfdcw_host_model.close_frame();
  endtask

  task automatic idle_grid(input string what);
    repeat (40)
    begin
      @(posedge clk_in);
      #1;
      check_level(what, 16'h0, grid);
    end
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    check_level("reset grid", 16'h0, grid);
    check_pattern("reset anodes", 35'h0, anode[0] | anode[1]);
    check_level("reset symbols", 16'h0, 16'({sym, stby}));
    idle_grid("grid at reset duty");
    $display("reset test done");
  endtask

  // defined opcodes only
  // Each write sends sixteen units from start address a, so the pointer always wraps.
  task automatic write_ram(input int l, input int kind, input logic [3:0] a);
    logic [7:0]  q[$];
    logic [63:0] p;
    q.push_back({4'(kind + 1 + 8 * l), a});
    for (int n = 0; n < 16; n++)
    begin
      p = {$random(seed), $random(seed)};
      if (kind == 0 && n % 4 == 0)
        p[7:4] = 4'h0;
      code_m[l][a] = (kind == 0) ? p[7:0] : code_m[l][a];
      sym_m[l][a]  = (kind == 2) ? p[0] : sym_m[l][a];
      pat_m[l][a]  = (kind == 1) ? p[34:0] : pat_m[l][a];
      if (kind != 1)
        q.push_back(p[7:0]);
      for (int k = 0; k < 5 && kind == 1; k++)
        q.push_back({p[40+k], p[k+30], p[k+25], p[k+20], p[k+15], p[k+10], p[k+5], p[k]});
      a = a + 4'h1;
    end
    frame(q);
  endtask

  function automatic logic [34:0] exp_pat(input int l, input int d, input int mode);
    logic [7:0] c;
    c = code_m[l][d];
    if (mode != 0)
      return (mode == 1) ? {35{1'b1}} : 35'h0;
    return (c < 8'h10) ? pat_m[l][c[3:0]] : {3'b000, c, c, c, c};
  endfunction

  task automatic scan(input int ndig, input int mode);
    int          hold;
    int          seen;
    logic [15:0] last;
    hold = 0;
    seen = 0;
    last = 16'h0;
    repeat (34 * SLOT)
    begin
      @(posedge clk_in);
      #1;
      hold = (grid === last) ? hold + 1 : 0;
      last = grid;
      for (int d = 0; d < 16 && hold == 4; d++)
        if (grid[d] === 1'b1)
        begin
          seen++;
          check_level("grid digit in range", 16'h1, 16'(d < ndig));
          for (int l = 0; l < 2; l++)
          begin
            check_pattern("anode pattern", exp_pat(l, d, mode), anode[l]);
            check_level("symbol", 16'(mode == 0 ? sym_m[l][d] : mode == 1), 16'(sym[l]));
          end
        end
    end
    check_level("digits scanned", 16'h1, 16'(seen >= ndig));
    $display("scan test done digits %0d mode %0d", ndig, mode);
  endtask

  initial
  begin
    do_reset();
    u_vfdcw_host_model.open_frame();
    u_vfdcw_host_model.send_bits(8'hff, 3);
    u_vfdcw_host_model.close_frame();
    frame('{8'h53, 8'hff});
    for (int l = 0; l < 2; l++)
      for (int k = 0; k < 3; k++)
        write_ram(l, k, 4'(k * 5 + 7));
    frame('{8'h70});
    scan(16, 0);
    frame('{8'h63});
    foreach (lights[i])
    begin
      frame('{lights[i]});
      scan(3, modes[i]);
    end
    // Lit cycles repeat with the slot, so any window of whole slots counts exactly.
    frame('{8'h51, 8'h01});
    repeat (4 * SLOT)
    begin
      @(posedge clk_in);
      #1;
      lit_n = lit_n + int'(grid != 16'h0);
    end
    check_level("lit cycles at duty five", 16'(4 * {8'h01, 2'b01}), 16'(lit_n));
    u_vfdcw_host_model.send_bits(8'hf0, 8);
    check_level("select high ignored", 16'h0, 16'(stby));
    $display("duty and select test done");
    frame('{8'h50, 8'h00});
    idle_grid("grid at duty zero");
    frame('{8'hf0});
    check_level("standby entered", 16'h1, 16'(stby));
    check_level("grid in standby", 16'h0, grid);
    u_vfdcw_host_model.open_frame();
    repeat (12) @(posedge clk_in);
    #1;
    check_level("standby left", 16'h0, 16'(stby));
    u_vfdcw_host_model.close_frame();
    $display("standby test done");
    do_reset();
    stop_test();
  end
endmodule
